// ### rtl/dtw_cfg.svh
// Register map, field positions and reset values of the delayed TX/RX warning block.
// Assumes byte addressing on a 32-bit APB bus, one register per aligned word.
`ifndef DTW_CFG_SVH
`define DTW_CFG_SVH

`define DTW_ADDR_W        8
`define DTW_OFF_CTRL      8'h00
`define DTW_OFF_DLY_TIME  8'h04
`define DTW_OFF_SYS_TIME  8'h08
`define DTW_OFF_STATUS    8'h0C
`define DTW_OFF_WARN_CNT  8'h10
`define DTW_OFF_IRQ_STAT  8'h14
`define DTW_OFF_IRQ_MASK  8'h18

`define DTW_CTRL_TX_BIT   0
`define DTW_CTRL_RX_BIT   1
`define DTW_CTRL_OFF_BIT  2
`define DTW_CTRL_EVC_BIT  3

`define DTW_ST_PEND_BIT   0
`define DTW_ST_ISRX_BIT   1
`define DTW_ST_WARN_BIT   27

`define DTW_IRQ_WARN_BIT  0
`define DTW_IRQ_GO_BIT    1
`define DTW_IRQ_W         2
`define DTW_IRQ_MASK_RST  2'h0

`endif

// ### rtl/dtw_pkg.sv
// Types shared by the delayed TX/RX warning block.
// Assumes dtw_cfg.svh supplies the register map.
package dtw_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dtw_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } dtw_apb_rsp_t;

  typedef struct packed {
    logic tx_start;
    logic rx_start;
  } dtw_go_t;
endpackage

// ### rtl/dtw_top.sv
// Delayed TX/RX scheduler with half-period warning, warning counter and interrupt.
// Assumes one clock pclk, an APB master on the register side, radio datapath outside.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "dtw_cfg.svh"

// How it works
// - Host writes target time, then a delayed TX or RX command starts the schedule.
// - Warning flag sets while remaining delay exceeds half the time counter wrap period.
// - The warning flag is read-only; writes to the status register change nothing.
// - Warning clears on cancel or once remaining delay is no more than half period.
// - Each warning occurrence increments the warning counter while event counting is enabled.
// - Warning sits at bit 27 of status, and only concerns delayed TX/RX.
module dtw_top
  import dtw_pkg::*;
#(
  parameter int TIME_W = 32,                 // System time counter width
  parameter int CNT_W  = 12                  // Warning counter width
) (
  input  wire logic          pclk,           // Clock, 125 MHz
  input  wire logic          presetn,        // Async reset, active low
  input  wire dtw_pkg::dtw_apb_req_t apb_req, // APB request
  output dtw_pkg::dtw_apb_rsp_t      apb_rsp, // APB answer
  output dtw_pkg::dtw_go_t           go,      // One-cycle start strobes to the radio
  output logic               warn,           // Half-period warning level
  output logic               irq             // Level interrupt
);
  import dtw_pkg::*;

  typedef struct packed {
    logic [TIME_W-1:0]      time_ff;
    logic [TIME_W-1:0]      target_ff;
    logic                   pend_ff;
    logic                   isrx_ff;
    logic                   warn_ff;
    logic                   evc_ff;
    logic [CNT_W-1:0]       cnt_ff;
    logic [`DTW_IRQ_W-1:0]  ist_ff;
    logic [`DTW_IRQ_W-1:0]  imask_ff;
    logic                   irq_ff;
    dtw_apb_rsp_t           rsp_ff;
    dtw_go_t                go_ff;
  } dtw_state_t;

  dtw_state_t s_ff;
  dtw_state_t nxt_s;

  logic [TIME_W-1:0] rem;
  logic              late;
  logic              due;
  logic              acc;
  logic              wr;
  logic              rd;
  logic              cmd_tx;
  logic              cmd_rx;
  logic              cmd_off;
  logic [31:0]       rdata;
  logic              hit;
  logic [`DTW_IRQ_W-1:0] ev;

  // Modulo difference: a target already passed looks like a delay beyond half a wrap
  assign rem  = s_ff.target_ff - s_ff.time_ff;
  assign late = rem[TIME_W-1] && (|rem[TIME_W-2:0]);
  assign due  = s_ff.pend_ff && (rem == '0);

  // One wait state: pready rises on the second access cycle
  assign acc = apb_req.psel && apb_req.penable && s_ff.rsp_ff.pready;
  assign wr  = acc && apb_req.pwrite;
  assign rd  = acc && !apb_req.pwrite;

  assign cmd_off = wr && (apb_req.paddr == `DTW_OFF_CTRL) && apb_req.pwdata[`DTW_CTRL_OFF_BIT];
  assign cmd_tx  = wr && (apb_req.paddr == `DTW_OFF_CTRL) && apb_req.pwdata[`DTW_CTRL_TX_BIT];
  assign cmd_rx  = wr && (apb_req.paddr == `DTW_OFF_CTRL) && apb_req.pwdata[`DTW_CTRL_RX_BIT];

  always_comb begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    unique case (apb_req.paddr)
      `DTW_OFF_CTRL: begin
        rdata[`DTW_CTRL_EVC_BIT] = s_ff.evc_ff;
      end
      `DTW_OFF_DLY_TIME: begin
        rdata[TIME_W-1:0] = s_ff.target_ff;
      end
      `DTW_OFF_SYS_TIME: begin
        rdata[TIME_W-1:0] = s_ff.time_ff;
      end
      `DTW_OFF_STATUS: begin
        rdata[`DTW_ST_PEND_BIT] = s_ff.pend_ff;
        rdata[`DTW_ST_ISRX_BIT] = s_ff.isrx_ff;
        rdata[`DTW_ST_WARN_BIT] = s_ff.warn_ff;
      end
      `DTW_OFF_WARN_CNT: begin
        rdata[CNT_W-1:0] = s_ff.cnt_ff;
      end
      `DTW_OFF_IRQ_STAT: begin
        rdata[`DTW_IRQ_W-1:0] = s_ff.ist_ff;
      end
      `DTW_OFF_IRQ_MASK: begin
        rdata[`DTW_IRQ_W-1:0] = s_ff.imask_ff;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_s = s_ff;
    ev    = '0;
    nxt_s.time_ff = s_ff.time_ff + 1'b1;

    // APB answer
    nxt_s.rsp_ff.pready = apb_req.psel && apb_req.penable && !s_ff.rsp_ff.pready;
    if (apb_req.psel && apb_req.penable && !s_ff.rsp_ff.pready) begin
      nxt_s.rsp_ff.prdata  = apb_req.pwrite ? 32'h0000_0000 : rdata;
      nxt_s.rsp_ff.pslverr = !hit;
    end else begin
      nxt_s.rsp_ff.prdata  = 32'h0000_0000;
      nxt_s.rsp_ff.pslverr = 1'b0;
    end

    // Writes; STATUS, SYS_TIME and WARN_CNT ignore them
    if (wr && apb_req.paddr == `DTW_OFF_DLY_TIME) begin
      nxt_s.target_ff = apb_req.pwdata[TIME_W-1:0];
    end
    if (wr && apb_req.paddr == `DTW_OFF_CTRL) begin
      nxt_s.evc_ff = apb_req.pwdata[`DTW_CTRL_EVC_BIT];
    end
    if (wr && apb_req.paddr == `DTW_OFF_IRQ_MASK) begin
      nxt_s.imask_ff = apb_req.pwdata[`DTW_IRQ_W-1:0];
    end

    // Scheduling: cancel wins over a start in the same write; TX wins over RX
    nxt_s.go_ff = '0;
    if (cmd_off) begin
      nxt_s.pend_ff = 1'b0;
    end else if (cmd_tx || cmd_rx) begin
      nxt_s.pend_ff = 1'b1;
      nxt_s.isrx_ff = !cmd_tx;
    end else if (due) begin
      nxt_s.pend_ff        = 1'b0;
      nxt_s.go_ff.tx_start = !s_ff.isrx_ff;
      nxt_s.go_ff.rx_start = s_ff.isrx_ff;
      ev[`DTW_IRQ_GO_BIT]  = 1'b1;
    end

    // Compared every cycle; cleared as soon as pending drops or the delay is no longer beyond half a wrap
    nxt_s.warn_ff = s_ff.pend_ff && !cmd_off && !due && late;

    if (nxt_s.warn_ff && !s_ff.warn_ff) begin
      ev[`DTW_IRQ_WARN_BIT] = 1'b1;
      if (s_ff.evc_ff) begin
        nxt_s.cnt_ff = s_ff.cnt_ff + 1'b1;
      end
    end

    // Read clears, but an event in the same cycle survives
    if (rd && apb_req.paddr == `DTW_OFF_IRQ_STAT) begin
      nxt_s.ist_ff = ev;
    end else begin
      nxt_s.ist_ff = s_ff.ist_ff | ev;
    end
    nxt_s.irq_ff = |(nxt_s.ist_ff & s_ff.imask_ff);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff.time_ff   <= '0;
      s_ff.target_ff <= '0;
      s_ff.pend_ff   <= 1'b0;
      s_ff.isrx_ff   <= 1'b0;
      s_ff.warn_ff   <= 1'b0;
      s_ff.evc_ff    <= 1'b0;
      s_ff.cnt_ff    <= '0;
      s_ff.ist_ff    <= '0;
      s_ff.imask_ff  <= `DTW_IRQ_MASK_RST;
      s_ff.irq_ff    <= 1'b0;
      s_ff.rsp_ff    <= '0;
      s_ff.go_ff     <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign apb_rsp = s_ff.rsp_ff;
  assign go      = s_ff.go_ff;
  assign warn    = s_ff.warn_ff;
  assign irq     = s_ff.irq_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_warn_sets_late: assert property (
    s_ff.pend_ff && late && !cmd_off && !due |=> s_ff.warn_ff)
    else $error("warning not raised for late schedule");
  a_warn_needs_pend: assert property (
    s_ff.warn_ff |-> $past(s_ff.pend_ff))
    else $error("warning without pending operation");
  a_warn_clears_off: assert property (
    cmd_off |=> !s_ff.warn_ff && !s_ff.pend_ff)
    else $error("cancel did not clear warning");
  a_warn_clears_ok: assert property (
    !late |=> !s_ff.warn_ff)
    else $error("warning held with short delay");
  a_status_ro: assert property (
    wr && apb_req.paddr == `DTW_OFF_STATUS && !cmd_off && !due
      |=> s_ff.warn_ff == $past(s_ff.pend_ff && late))
    else $error("status write disturbed warning");
  a_cnt_counts: assert property (
    $rose(s_ff.warn_ff) && $past(s_ff.evc_ff)
      |-> s_ff.cnt_ff == $past(s_ff.cnt_ff) + 1'b1)
    else $error("warning counter missed an event");
  a_cnt_holds: assert property (
    !$rose(s_ff.warn_ff) || !$past(s_ff.evc_ff) |-> $stable(s_ff.cnt_ff))
    else $error("warning counter moved without cause");
  a_cmd_pends: assert property (
    (cmd_tx || cmd_rx) && !cmd_off |=> s_ff.pend_ff)
    else $error("delayed command did not start schedule");
  a_go_on_due: assert property (
    due && !cmd_off && !cmd_tx && !cmd_rx
      |=> (go.tx_start || go.rx_start) ##1 !go.tx_start && !go.rx_start)
    else $error("start strobe wrong at target time");
  a_warn_bit27: assert property (
    rd && apb_req.paddr == `DTW_OFF_STATUS
      |-> apb_rsp.prdata[`DTW_ST_WARN_BIT] == $past(s_ff.warn_ff))
    else $error("warning not at status bit 27");

  c_late_warn:  cover property ($rose(s_ff.warn_ff));
  c_cancel:     cover property (s_ff.warn_ff ##1 cmd_off);
  c_rx_started: cover property (go.rx_start);
  c_irq:        cover property ($rose(irq));
endmodule

// ### bench/dtw_host.sv
// Host model: APB master that schedules and cancels delayed transceiver operations.
// Assumes dtw_top answers every access with pready; clock comes from the bench.
`timescale 1ns/10ps
`include "dtw_cfg.svh"
module dtw_host
  import dtw_pkg::*;
(
  input  wire logic          pclk,  // Bus clock
  output dtw_pkg::dtw_apb_req_t req,   // Request to the block
  input  wire dtw_pkg::dtw_apb_rsp_t rsp // Answer from the block
);
  initial req = '0;

  // Released lines show inverted values so no stale address or data passes for valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '{1'b0, 1'b0, w, ~a, ~d};
  endtask

  // Target time first, then the command
  task automatic sched(input logic [31:0] target, input logic [31:0] cmd);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, `DTW_OFF_DLY_TIME, target, q, e);
    xfer(1'b1, `DTW_OFF_CTRL, cmd, q, e);
  endtask
endmodule

// ### bench/dtw_top_bench.sv
// Self-checking bench for the delayed TX/RX warning block.
// Assumes dtw_host as the APB master and the register map of dtw_cfg.svh.
`timescale 1ns/10ps
`include "dtw_cfg.svh"
module dtw_top_bench;
  import dtw_pkg::*;
  logic         pclk;
  logic         presetn;
  dtw_apb_req_t apb_req;
  dtw_apb_rsp_t apb_rsp;
  dtw_go_t      go;
  logic         warn;
  logic         irq;
  logic [31:0]  q;
  logic [31:0]  t;
  logic         e;
  int           error_cnt;
  int           checked;
  int           n;

  dtw_top u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
                 .go(go), .warn(warn), .irq(irq));
  dtw_host u_host (.pclk(pclk), .req(apb_req), .rsp(apb_rsp));

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    presetn = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DTW_OFF_IRQ_MASK);
    chk("irq_mask reset", q, 32'h0);
    rd(`DTW_OFF_WARN_CNT);
    chk("warn_cnt reset", q, 32'h0);
    // Timely delayed TX with event counting on
    wr(`DTW_OFF_CTRL, 32'h8);
    rd(`DTW_OFF_SYS_TIME);
    t = q;
    u_host.sched(t + 32'd100, 32'h9);
    rd(`DTW_OFF_STATUS);
    chk("status timely tx", q, 32'h1);
    @(negedge pclk);
    chk("warn timely", warn, 1'b0);
    for (n = 0; n < 300 && go.tx_start !== 1'b1; n++) @(negedge pclk);
    chk("tx start", go, 2'h2);
    // Late delayed RX: target already passed, so remaining wraps past half period
    rd(`DTW_OFF_SYS_TIME);
    u_host.sched(q - 32'd50, 32'hA);
    repeat (4) @(negedge pclk);
    chk("warn late", warn, 1'b1);
    wr(`DTW_OFF_STATUS, 32'h0);
    rd(`DTW_OFF_STATUS);
    chk("status late rx", q, 32'h0800_0003);
    rd(`DTW_OFF_WARN_CNT);
    chk("warn_cnt counted", q, 32'h1);
    wr(`DTW_OFF_CTRL, 32'hC);
    rd(`DTW_OFF_STATUS);
    // Kind bit keeps the last command after a cancel; only pending and warning drop
    chk("status cancel", q, 32'h2);
    @(negedge pclk);
    chk("warn cancel", warn, 1'b0);
    // Interrupt: masked events stay silent, unmasked warning raises irq, read clears
    chk("irq masked", irq, 1'b0);
    rd(`DTW_OFF_IRQ_STAT);
    chk("irq_stat events", q, 32'h3);
    wr(`DTW_OFF_IRQ_MASK, 32'h1);
    wr(`DTW_OFF_CTRL, 32'h0);
    rd(`DTW_OFF_SYS_TIME);
    u_host.sched(q - 32'd50, 32'h1);
    repeat (5) @(negedge pclk);
    chk("irq raised", irq, 1'b1);
    wr(`DTW_OFF_CTRL, 32'h4);
    rd(`DTW_OFF_IRQ_STAT);
    chk("irq_stat warn", q, 32'h1);
    repeat (3) @(negedge pclk);
    chk("irq cleared", irq, 1'b0);
    rd(`DTW_OFF_WARN_CNT);
    chk("warn_cnt idle", q, 32'h1);
    // Timely delayed RX ends in the receive strobe; its event is masked
    rd(`DTW_OFF_SYS_TIME);
    u_host.sched(q + 32'd60, 32'h2);
    @(negedge pclk);
    chk("warn timely rx", warn, 1'b0);
    for (n = 0; n < 300 && go.rx_start !== 1'b1; n++) @(negedge pclk);
    chk("rx start", go, 2'h1);
    chk("irq go masked", irq, 1'b0);
    rd(8'h40);
    chk("unmapped err", e, 1'b1);
    wrap_up();
  end
endmodule
